/* File: rtl/pll_aux_regs_cfg.svh */
// Register offsets, field positions, write masks and reset values of the synthesizer register group.
`ifndef PLL_AUX_REGS_CFG_SVH
`define PLL_AUX_REGS_CFG_SVH

`define ADDR_SEARCH_ERROR_STATUS 5'h11
`define ADDR_OUTPUT_LOCK_STATUS 5'h12
`define ADDR_SELF_TEST_STATUS 5'h13
`define ADDR_AUXILIARY_PORT_CONTROL 5'h14
`define ADDR_MANUAL_OSCILLATOR_CONFIG 5'h15
`define ADDR_OUTPUT_DIVIDER_GAIN 5'h16

`define RST_SEARCH_MAG 19'h7ffff
`define RST_LOCK_RESERVED 22'h000007
`define RST_SELF_TEST 24'h001259
`define RST_AUXILIARY_PORT_CONTROL 24'h000220
`define RST_MANUAL_OSCILLATOR_CONFIG 24'h0f48a0
`define RST_OUTPUT_DIVIDER_GAIN 24'h0006c1

`define MASK_AUXILIARY_PORT_CONTROL 24'h003e1f
`define MASK_MANUAL_OSCILLATOR_CONFIG 24'h0103ff
`define MASK_OUTPUT_DIVIDER_GAIN 24'h0007ff

`define BIT_AUX_SERIAL_MODE 0
`define LSB_AUX_STATIC_VALUE 1
`define BIT_AUX_LEVEL_3V3 4
`define BIT_PHASE_SYNC 9
`define LSB_AUX_ROUTE 10
`define LSB_AUX_IDLE 12

`define BIT_MANUAL_CAL 0
`define LSB_CAP_SWITCH 1
`define LSB_SUBBAND 6
`define BIT_MANUAL_TUNE 9
`define BIT_CP_AUTOSCALE 16

`define LSB_DIV_RATIO 0
`define DIV_RATIO_MAX 6'h3e
`define LSB_LO1_GAIN 6
`define LSB_LO2_GAIN 8
`define BIT_DIV_STAGE_GAIN 10

`define IDLE_HIZ 2'h0
`define IDLE_KEEP 2'h1
`define IDLE_HIGH 2'h2
`define IDLE_LOW 2'h3

`endif

/* File: rtl/pll_aux_regs_pkg.sv */
// Types shared by the synthesizer register group.
package pll_aux_regs_pkg;
  typedef logic [23:0] reg_word_t;
  typedef logic [4:0] reg_addr_t;
  typedef enum logic [1:0] {AUX_IDLE_HIZ, AUX_IDLE_KEEP, AUX_IDLE_HIGH, AUX_IDLE_LOW} aux_idle_t;
endpackage

/* File: rtl/pll_aux_vco_divider_regs.sv */
// Status and configuration registers for auxiliary port, manual oscillator and output divider.
// Overview of operation
// - Read-only signed calibration search error, magnitude resets ones.
// - Serial mode bit picks serial or static aux.
// - Static mode drives aux pins from value field.
// - Level bit selects 1.8 V or 3.3 V.
// - Phase sync turns enable pin into restart.
// - Routing field copies general output onto aux pin.
// - Idle field sets disabled aux pin state.
// - Manual calibration bit overrides automatic result.
// - Manual sub-band and capacitor fields, resets 2, 16.
// - Manual tuning bit enables manual tuning.
// - Auto-scale bit scales charge pump current.
// - Divide value zero mutes RF output stages.
// - Divide ratio above 1 clipped to even values, max 62; ratio 1 passes unchanged.
// - Status general output carries selected internal signal.
`include "pll_aux_regs_cfg.svh"

module pll_aux_vco_divider_regs
  import pll_aux_regs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire reg_addr_t reg_addr,
  input wire reg_word_t reg_wdata,
  output reg_word_t reg_rdata,
  output logic reg_rvalid,
  input wire logic search_update,
  input wire logic [18:0] search_magnitude,
  input wire logic search_sign,
  input wire logic lock_detect,
  input wire logic [4:0] general_output_mux_select,
  input wire logic [31:0] general_output_mux_sources,
  input wire logic [2:0] aux_serial_data,
  input wire logic aux_serial_active,
  input wire logic chip_enable_pin,
  input wire logic [2:0] auto_subband,
  input wire logic [4:0] auto_cap_switch,
  output logic [2:0] aux_out,
  output logic [2:0] aux_oe,
  output logic aux_level_3v3,
  output logic phase_restart,
  output logic manual_cal_en,
  output logic [2:0] vco_subband,
  output logic [4:0] cap_switch,
  output logic manual_tune_en,
  output logic charge_pump_autoscale,
  output logic rf_mute,
  output logic [5:0] rf_divide,
  output logic [1:0] lo1_gain,
  output logic [1:0] lo2_gain,
  output logic divider_stage_gain
);

  // Writable register images; reserved bits are pinned to their reset values.
  reg_word_t aux_ctrl;
  reg_word_t osc_cfg;
  reg_word_t div_gain;
  // Status state captured from the synthesizer.
  logic [18:0] search_mag;
  logic search_neg;
  logic general_output;
  logic lock_seen;
  // Enable pin synchroniser and edge history.
  logic chip_en_meta;
  logic chip_en_sync;
  logic chip_en_prev;
  logic [5:0] next_divide;
  aux_idle_t idle_mode;

  assign idle_mode = aux_idle_t'(aux_ctrl[`LSB_AUX_IDLE +: 2]);

  // Host writes; status offsets have no write path, so writes there do nothing.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aux_ctrl <= `RST_AUXILIARY_PORT_CONTROL;
      osc_cfg <= `RST_MANUAL_OSCILLATOR_CONFIG;
      div_gain <= `RST_OUTPUT_DIVIDER_GAIN;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_AUXILIARY_PORT_CONTROL: begin
          aux_ctrl <= (reg_wdata & `MASK_AUXILIARY_PORT_CONTROL) |
                      (`RST_AUXILIARY_PORT_CONTROL & ~`MASK_AUXILIARY_PORT_CONTROL);
        end
        `ADDR_MANUAL_OSCILLATOR_CONFIG: begin
          osc_cfg <= (reg_wdata & `MASK_MANUAL_OSCILLATOR_CONFIG) |
                     (`RST_MANUAL_OSCILLATOR_CONFIG & ~`MASK_MANUAL_OSCILLATOR_CONFIG);
        end
        `ADDR_OUTPUT_DIVIDER_GAIN: begin
          div_gain <= (reg_wdata & `MASK_OUTPUT_DIVIDER_GAIN) |
                      (`RST_OUTPUT_DIVIDER_GAIN & ~`MASK_OUTPUT_DIVIDER_GAIN);
        end
        default: begin
        end
      endcase
    end
  end

  // The search result is held until the calibration engine posts a new one.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      search_mag <= `RST_SEARCH_MAG;
      search_neg <= 1'b0;
    end else if (search_update) begin
      search_mag <= search_magnitude;
      search_neg <= search_sign;
    end
  end

  // General output follows the select field held elsewhere; lock detect is also kept.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      general_output <= 1'b0;
      lock_seen <= 1'b0;
    end else begin
      general_output <= general_output_mux_sources[general_output_mux_select];
      lock_seen <= lock_detect;
    end
  end

  // Read port; answers one cycle after the strobe, unmapped offsets read zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_SEARCH_ERROR_STATUS: reg_rdata <= {4'h0, search_neg, search_mag};
          `ADDR_OUTPUT_LOCK_STATUS: begin
            reg_rdata <= {`RST_LOCK_RESERVED, lock_seen, general_output};
          end
          `ADDR_SELF_TEST_STATUS: reg_rdata <= `RST_SELF_TEST;
          `ADDR_AUXILIARY_PORT_CONTROL: reg_rdata <= aux_ctrl;
          `ADDR_MANUAL_OSCILLATOR_CONFIG: reg_rdata <= osc_cfg;
          `ADDR_OUTPUT_DIVIDER_GAIN: reg_rdata <= div_gain;
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // Each auxiliary pin: routed general output wins, then serial or static, then idle state.
  for (genvar i = 0; i < 3; i++) begin : g_aux
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        aux_out[i] <= 1'b0;
        aux_oe[i] <= 1'b0;
      end else if (aux_ctrl[`LSB_AUX_ROUTE +: 2] == 2'(i + 1)) begin
        aux_out[i] <= general_output;
        aux_oe[i] <= 1'b1;
      end else if (!aux_ctrl[`BIT_AUX_SERIAL_MODE]) begin
        aux_out[i] <= aux_ctrl[`LSB_AUX_STATIC_VALUE + i];
        aux_oe[i] <= 1'b1;
      end else if (aux_serial_active) begin
        aux_out[i] <= aux_serial_data[i];
        aux_oe[i] <= 1'b1;
      end else begin
        // A disabled serial port parks its pins; keep reuses the pin's own flop as memory.
        case (idle_mode)
          AUX_IDLE_HIZ: aux_oe[i] <= 1'b0;
          AUX_IDLE_KEEP: aux_oe[i] <= 1'b1;
          AUX_IDLE_HIGH: begin
            aux_out[i] <= 1'b1;
            aux_oe[i] <= 1'b1;
          end
          AUX_IDLE_LOW: begin
            aux_out[i] <= 1'b0;
            aux_oe[i] <= 1'b1;
          end
          default: aux_oe[i] <= 1'b0;
        endcase
      end
    end
  end

  // The enable pin is asynchronous, so only the second flop feeds the edge detector.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chip_en_meta <= 1'b0;
      chip_en_sync <= 1'b0;
      chip_en_prev <= 1'b0;
      phase_restart <= 1'b0;
    end else begin
      chip_en_meta <= chip_enable_pin;
      chip_en_sync <= chip_en_meta;
      chip_en_prev <= chip_en_sync;
      // Exact frequency mode is the host's duty; without it the restart is meaningless.
      phase_restart <= aux_ctrl[`BIT_PHASE_SYNC] & chip_en_sync & ~chip_en_prev;
    end
  end

  // Invalid ratios fold down: odd values above 1 drop to the even one below, large ones clip; 1 is kept.
  always_comb begin
    next_divide = div_gain[`LSB_DIV_RATIO +: 6];
    if (next_divide > `DIV_RATIO_MAX) begin
      next_divide = `DIV_RATIO_MAX;
    end else if (next_divide > 6'h01) begin
      next_divide = {next_divide[5:1], 1'b0};
    end
  end

  // Analogue controls, registered so every pin leaves from a flop.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aux_level_3v3 <= 1'b0;
      manual_cal_en <= 1'b0;
      vco_subband <= 3'h0;
      cap_switch <= 5'h00;
      manual_tune_en <= 1'b0;
      charge_pump_autoscale <= 1'b0;
      rf_mute <= 1'b0;
      rf_divide <= 6'h00;
      lo1_gain <= 2'h0;
      lo2_gain <= 2'h0;
      divider_stage_gain <= 1'b0;
    end else begin
      aux_level_3v3 <= aux_ctrl[`BIT_AUX_LEVEL_3V3];
      manual_cal_en <= osc_cfg[`BIT_MANUAL_CAL];
      vco_subband <= osc_cfg[`BIT_MANUAL_CAL] ? osc_cfg[`LSB_SUBBAND +: 3] : auto_subband;
      cap_switch <= osc_cfg[`BIT_MANUAL_CAL] ? osc_cfg[`LSB_CAP_SWITCH +: 5] : auto_cap_switch;
      manual_tune_en <= osc_cfg[`BIT_MANUAL_TUNE];
      charge_pump_autoscale <= osc_cfg[`BIT_CP_AUTOSCALE];
      rf_mute <= (div_gain[`LSB_DIV_RATIO +: 6] == 6'h00);
      rf_divide <= next_divide;
      lo1_gain <= div_gain[`LSB_LO1_GAIN +: 2];
      lo2_gain <= div_gain[`LSB_LO2_GAIN +: 2];
      divider_stage_gain <= div_gain[`BIT_DIV_STAGE_GAIN];
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // The read captures the result held before the read edge, so a same-edge update is allowed.
  property p_search_read;
    reg_rd && reg_addr == `ADDR_SEARCH_ERROR_STATUS |=>
      reg_rvalid && reg_rdata[18:0] == $past(search_mag) &&
      reg_rdata[19] == $past(search_neg) && reg_rdata[23:20] == 4'h0;
  endproperty
  a_search_read: assert property (p_search_read) else $error("search status read wrong");

  property p_static_drive;
    aux_ctrl[`BIT_AUX_SERIAL_MODE] == 1'b0 && aux_ctrl[11:10] == 2'h0 |=>
      aux_oe == 3'h7 && aux_out == $past(aux_ctrl[3:1]);
  endproperty
  a_static_drive: assert property (p_static_drive) else $error("static aux drive wrong");

  property p_serial_drive;
    aux_ctrl[0] && aux_serial_active && aux_ctrl[11:10] == 2'h0 |=>
      aux_out == $past(aux_serial_data);
  endproperty
  a_serial_drive: assert property (p_serial_drive) else $error("serial aux drive wrong");

  property p_route;
    aux_ctrl[11:10] == 2'h2 |=> aux_oe[1] && aux_out[1] == $past(general_output);
  endproperty
  a_route: assert property (p_route) else $error("general output route wrong");

  property p_idle_hiz;
    aux_ctrl[0] && !aux_serial_active && aux_ctrl[13:10] == 4'h0 |=> aux_oe == 3'h0;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("idle pins not released");

  property p_phase;
    $rose(chip_en_sync) && aux_ctrl[`BIT_PHASE_SYNC] |=> phase_restart ##1 !phase_restart;
  endproperty
  a_phase: assert property (p_phase) else $error("phase restart pulse wrong");

  property p_mute;
    div_gain[5:0] == 6'h00 |=> rf_mute && rf_divide == 6'h00;
  endproperty
  a_mute: assert property (p_mute) else $error("mute not applied");

  property p_divide;
    div_gain[5:0] > 6'h01 |=> !rf_mute && !rf_divide[0] && rf_divide <= 6'h3e &&
      rf_divide >= 6'h02;
  endproperty
  a_divide: assert property (p_divide) else $error("divide ratio not folded");

  property p_manual_band;
    osc_cfg[0] |=> vco_subband == $past(osc_cfg[8:6]) && cap_switch == $past(osc_cfg[5:1]);
  endproperty
  a_manual_band: assert property (p_manual_band) else $error("manual band not used");

  property p_status_write;
    reg_wr && reg_addr == `ADDR_SELF_TEST_STATUS |=> $stable(aux_ctrl) && $stable(osc_cfg)
      && $stable(div_gain);
  endproperty
  a_status_write: assert property (p_status_write) else $error("status write changed state");

  // Both status bits come from their own flops, so they are checked against those flops.
  property p_lock_read;
    reg_rd && reg_addr == `ADDR_OUTPUT_LOCK_STATUS |=>
      reg_rdata == {`RST_LOCK_RESERVED, $past(lock_seen), $past(general_output)};
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock status read wrong");

  property p_test_read;
    reg_rd && reg_addr == `ADDR_SELF_TEST_STATUS |=> reg_rdata == `RST_SELF_TEST;
  endproperty
  a_test_read: assert property (p_test_read) else $error("self test wrong");

  // The attempt starts after reset, so the reset-time zeros of the outputs are never compared.
  property p_level;
    1'b1 |=> aux_level_3v3 == $past(aux_ctrl[`BIT_AUX_LEVEL_3V3]);
  endproperty
  a_level: assert property (p_level) else $error("aux level wrong");

  property p_manual_cal;
    1'b1 |=> manual_cal_en == $past(osc_cfg[`BIT_MANUAL_CAL]);
  endproperty
  a_manual_cal: assert property (p_manual_cal) else $error("manual calibration wrong");

  property p_auto_band;
    !osc_cfg[`BIT_MANUAL_CAL] |=>
      vco_subband == $past(auto_subband) && cap_switch == $past(auto_cap_switch);
  endproperty
  a_auto_band: assert property (p_auto_band) else $error("automatic band not used");

  property p_manual_tune;
    1'b1 |=> manual_tune_en == $past(osc_cfg[`BIT_MANUAL_TUNE]);
  endproperty
  a_manual_tune: assert property (p_manual_tune) else $error("manual tune wrong");

  property p_autoscale;
    1'b1 |=> charge_pump_autoscale == $past(osc_cfg[`BIT_CP_AUTOSCALE]);
  endproperty
  a_autoscale: assert property (p_autoscale) else $error("autoscale wrong");

  property p_lo1_gain;
    1'b1 |=> lo1_gain == $past(div_gain[`LSB_LO1_GAIN +: 2]);
  endproperty
  a_lo1_gain: assert property (p_lo1_gain) else $error("first buffer gain wrong");

  property p_lo2_gain;
    1'b1 |=> lo2_gain == $past(div_gain[`LSB_LO2_GAIN +: 2]);
  endproperty
  a_lo2_gain: assert property (p_lo2_gain) else $error("second buffer gain wrong");

  property p_stage_gain;
    1'b1 |=> divider_stage_gain == $past(div_gain[`BIT_DIV_STAGE_GAIN]);
  endproperty
  a_stage_gain: assert property (p_stage_gain) else $error("stage gain wrong");

  // Keep mode must hold the pins exactly where the last driven cycle left them.
  property p_idle_keep;
    aux_ctrl[0] && !aux_serial_active && aux_ctrl[13:10] == 4'h4 |=>
      aux_oe == 3'h7 && aux_out == $past(aux_out);
  endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("idle keep lost value");

  property p_idle_high;
    aux_ctrl[0] && !aux_serial_active && aux_ctrl[13:10] == 4'h8 |=>
      aux_oe == 3'h7 && aux_out == 3'h7;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle high not driven");

  property p_phase_off;
    !aux_ctrl[`BIT_PHASE_SYNC] |=> !phase_restart;
  endproperty
  a_phase_off: assert property (p_phase_off) else $error("restart without sync");

endmodule // pll_aux_vco_divider_regs

/* File: verif/host_model.sv */
// Host controller model that issues register reads and writes on the register port.
module host_model
  import pll_aux_regs_pkg::*;
(
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output reg_addr_t reg_addr,
  output reg_word_t reg_wdata,
  input wire reg_word_t reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Strobes start low so no request is made while reset is held.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 24'h000000;
  end

  // Released lines show the inverse of the last value, so stale data can never pass for a match.
  task automatic wr(input reg_addr_t a, input reg_word_t w);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~w;
  endtask

  // The answer stands for one cycle after the taken edge, so it is sampled just after that edge.
  task automatic rd(input reg_addr_t a, output reg_word_t d, output logic v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule // host_model

/* File: verif/tb_pll_aux_vco_divider_regs.sv */
// Self-checking testbench for the synthesizer register group.
module tb_pll_aux_vco_divider_regs
  import pll_aux_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, v, restart, cal, tune, cp, mute, st, lvl;
  reg_addr_t reg_addr;
  reg_word_t reg_wdata, reg_rdata, d;
  logic upd = 1'b0, sact = 1'b0, cen = 1'b0, lock = 1'b1, sign = 1'b1;
  logic [18:0] mag = 19'h12345;
  logic [4:0] sel = 5'h03, acap = 5'h0a, cap;
  logic [31:0] src = 32'h00000008;
  logic [2:0] sdat = 3'h6, asb = 3'h5, aux_out, aux_oe, sb;
  logic [5:0] div;
  logic [1:0] lo1, lo2;
  int n_fail = 0, checks_done = 0, n;
  localparam reg_addr_t ra[5] = '{5'h11, 5'h13, 5'h14, 5'h15, 5'h16};
  localparam reg_word_t rv[5] = '{24'h07ffff, 24'h001259, 24'h000220, 24'h0f48a0, 24'h0006c1};
  localparam reg_word_t dw[5] = '{24'h000000, 24'h000641, 24'h00003d, 24'hffffff, 24'h000003};
  localparam reg_word_t de[5] = '{24'h000800, 24'h00002d, 24'h000780, 24'h0007df, 24'h000040};
  localparam reg_word_t aw[9] = '{24'h00001a, 24'h000800, 24'h000001, 24'h003001, 24'h002001,
    24'h001001, 24'h000001, 24'h000c00, 24'h000401};
  localparam logic [6:0] ae[9] = '{7'h5f, 7'h2e, 7'h6e, 7'h0e, 7'h7e, 7'h7e, 7'h00, 7'h4e, 7'h7e};
  localparam logic [8:0] aa = 9'b001000001;

  // Free-running system clock, 10 ns period.
  always #5 clk_sys = ~clk_sys;

  pll_aux_vco_divider_regs dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .search_update(upd), .search_magnitude(mag), .search_sign(sign), .lock_detect(lock),
    .general_output_mux_select(sel), .general_output_mux_sources(src),
    .aux_serial_data(sdat), .aux_serial_active(sact), .chip_enable_pin(cen),
    .auto_subband(asb), .auto_cap_switch(acap), .aux_out(aux_out), .aux_oe(aux_oe),
    .aux_level_3v3(lvl), .phase_restart(restart), .manual_cal_en(cal), .vco_subband(sb),
    .cap_switch(cap), .manual_tune_en(tune), .charge_pump_autoscale(cp), .rf_mute(mute),
    .rf_divide(div), .lo1_gain(lo1), .lo2_gain(lo2), .divider_stage_gain(st));

  host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // Case equality keeps an unknown from passing as a match.
  task automatic chk(input string s, input reg_word_t e, input reg_word_t g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic rchk(input reg_addr_t a, input reg_word_t e);
    host.rd(a, d, v);
    chk("rvalid", 24'h000001, {23'h0, v});
    chk("rdata", e, d);
  endtask

  // Derived outputs settle one edge after the write is taken.
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rchk(ra[i], rv[i]);
    rchk(5'h12, 24'h00001f);
    chk("divider", 24'h00003d, {12'h0, mute, div, lo1, lo2, st});
    chk("autoscale", 24'h000001, {23'h0, cp});
    $display("test reset done");
    @(posedge clk_sys);
    upd <= 1'b1;
    @(posedge clk_sys);
    upd <= 1'b0;
    host.wr(5'h11, 24'h000000);
    host.wr(5'h13, 24'h000000);
    rchk(5'h11, 24'h092345);
    rchk(5'h13, 24'h001259);
    rchk(5'h1f, 24'h000000);
    // Lock and general output are moved one at a time so each status bit is seen alone.
    @(posedge clk_sys);
    lock <= 1'b0;
    rchk(5'h12, 24'h00001d);
    @(posedge clk_sys);
    lock <= 1'b1;
    sel <= 5'h00;
    rchk(5'h12, 24'h00001e);
    @(posedge clk_sys);
    sel <= 5'h03;
    $display("test status done");
    // The first pass ends by clearing the sync enable, so the pin rise in the second pass must go unanswered.
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      cen <= 1'b1;
      n = 0;
      repeat (8) begin
        step();
        n = n + restart;
      end
      chk("restart", 24'(1 - k), 24'(n));
      @(posedge clk_sys);
      cen <= 1'b0;
      host.wr(5'h14, 24'h000000);
    end
    $display("test phase done");
    host.wr(5'h15, 24'hffffff);
    step();
    chk("osc", 24'h0007ff, {13'h0, cal, sb, cap, tune, cp});
    rchk(5'h15, 24'h0f4bff);
    host.wr(5'h15, 24'h000000);
    step();
    chk("osc", 24'h0002a8, {13'h0, cal, sb, cap, tune, cp});
    rchk(5'h15, 24'h0e4800);
    $display("test oscillator done");
    for (int i = 0; i < 5; i++) begin
      host.wr(5'h16, dw[i]);
      step();
      chk("divider", de[i], {12'h0, mute, div, lo1, lo2, st});
      rchk(5'h16, dw[i] & 24'h0007ff);
    end
    $display("test divider done");
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_sys);
      sact <= aa[8 - i];
      host.wr(5'h14, aw[i]);
      step();
      chk("aux", {17'h0, ae[i]}, {17'h0, aux_out & aux_oe, aux_oe, lvl});
      rchk(5'h14, (aw[i] & 24'h003e1f) | 24'h000020);
    end
    $display("test aux done");
    complete_run();
  end

  // Watchdog well beyond the roughly 150 cycles the tests need.
  initial begin
    #50us;
    n_fail++;
    $display("ERROR watchdog expected finish seen timeout");
    complete_run();
  end
endmodule // tb_pll_aux_vco_divider_regs
